// >>> dv/gtr_pin_src.sv
// far side model: external clock or gate source and low power oscillator waveform
`timescale 1ns/1ns
module gtr_pin_src (
  input  wire logic ref_clk,
  output logic      pin,
  output logic      lpClk
);
  // both lines stand still low between pulses, like a stopped source
  initial begin
    pin = 1'b0;
    lpClk = 1'b0;
  end

  // n pulses, each high for hi cycles, then low for four so the synchroniser settles
  task automatic pulses(input bit lp, input int n, input int hi);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      if (lp) lpClk <= 1'b1;
      else pin <= 1'b1;
      repeat (hi) @(posedge ref_clk);
      if (lp) lpClk <= 1'b0;
      else pin <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule

// >>> dv/testbench.sv
// self-checking bench: timer scenarios as sequences of register accesses
`timescale 1ns/1ns
module testbench;
  logic                  ref_clk;
  logic                  arst_n;
  logic                  cpuIdle;
  logic                  cpuSleep;
  logic                  irq;
  logic                  wakeEvent;
  logic                  wakeSeen = 1'b0;
  logic                  extPin;
  logic                  lpClk;
  logic [31:0]           rd;
  logic [1:0]            rs;
  gtr_pkg::gtr_axi_req_s req;
  gtr_pkg::gtr_axi_rsp_s rsp;
  int                    fails;
  int                    nTests;
  int                    divs [4] = '{1, 8, 64, 256};

  gtr_timer u_dut (
    .ref_clk         (ref_clk),
    .arst_n          (arst_n),
    .clkEn           (1'b1),
    .axiReq          (req),
    .axiRsp          (rsp),
    .extClockGatePin (extPin),
    .lpOscClk        (lpClk),
    .cpuIdle         (cpuIdle),
    .cpuSleep        (cpuSleep),
    .irq             (irq),
    .wakeEvent       (wakeEvent)
  );

  gtr_pin_src u_src (
    .ref_clk (ref_clk),
    .pin     (extPin),
    .lpClk   (lpClk)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // the wake pulse lasts one cycle, so it is caught here rather than polled
  always @(posedge ref_clk) begin
    if (wakeEvent === 1'b1) wakeSeen <= 1'b1;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [11:0] ba(input logic [11:0] idx);
    return idx * gtr_pkg::IDX_TO_BYTE;
  endfunction

  task automatic wr(input logic [11:0] idx, input logic [15:0] d);
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= ba(idx);
    req.wvalid <= 1'b1;
    req.wdata <= {16'h0000, d};
    req.wstrb <= 4'h3;
    req.bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    rs = rsp.bresp;
  endtask

  task automatic rdr(input logic [11:0] idx);
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= ba(idx);
    req.rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    rd = rsp.rdata;
    rs = rsp.rresp;
  endtask

  task automatic rc(input string what, input logic [11:0] idx, input logic [15:0] exp);
    rdr(idx);
    chk(what, {16'h0000, exp}, rd);
  endtask

  task automatic conclude();
    if (fails == 0 && nTests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // longest path is the 1:256 gated pulse; the rest is a few hundred cycles
  initial begin
    #300000;
    fails++;
    conclude();
  end

  initial begin
    arst_n = 1'b0;
    cpuIdle = 1'b0;
    cpuSleep = 1'b0;
    req = '0;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    rc("period", gtr_pkg::IDX_PERIOD, 16'hffff);
    wr(12'h0ff, 16'h1234);
    chk("bresp", {30'h0, gtr_pkg::RESP_SLVERR}, {30'h0, rs});
    rdr(12'h0ff);
    chk("rresp", {30'h0, gtr_pkg::RESP_SLVERR}, {30'h0, rs});
    chk("rdata", 32'h0, rd);
    rc("count", gtr_pkg::IDX_COUNT, 16'h0000);
    wr(gtr_pkg::IDX_PERIOD, 16'h0002);
    chk("bresp ok", {30'h0, gtr_pkg::RESP_OKAY}, {30'h0, rs});
    wr(gtr_pkg::IDX_IRQ_MASK, 16'h0001);
    wr(gtr_pkg::IDX_CONTROL, 16'h8000);
    repeat (4) @(posedge ref_clk);
    rc("status", gtr_pkg::IDX_IRQ_STATUS, 16'h0001);
    chk("irq", 32'h1, {31'h0, irq});
    wr(gtr_pkg::IDX_CONTROL, 16'h0000);
    wr(gtr_pkg::IDX_IRQ_STATUS, 16'h0001);
    rc("status", gtr_pkg::IDX_IRQ_STATUS, 16'h0000);
    chk("irq", 32'h0, {31'h0, irq});
    wr(gtr_pkg::IDX_COUNT, 16'h0005);
    wr(gtr_pkg::IDX_CONTROL, 16'h5fb9);
    rc("control", gtr_pkg::IDX_CONTROL, 16'h0030);
    rc("count", gtr_pkg::IDX_COUNT, 16'h0005);
    wr(gtr_pkg::IDX_PERIOD, 16'hffff);
    for (int p = 0; p < 4; p++) begin
      wr(gtr_pkg::IDX_CONTROL, 16'h8040 | 16'(p << 4));
      wr(gtr_pkg::IDX_COUNT, 16'h0000);
      u_src.pulses(1'b0, 1, 2 * divs[p]);
      rc("gated count", gtr_pkg::IDX_COUNT, 16'h0002);
      rc("gate fall", gtr_pkg::IDX_IRQ_STATUS, 16'h0001);
      wr(gtr_pkg::IDX_IRQ_STATUS, 16'h0001);
    end
    wr(gtr_pkg::IDX_CONTROL, 16'ha040);
    wr(gtr_pkg::IDX_COUNT, 16'h0000);
    cpuIdle <= 1'b1;
    u_src.pulses(1'b0, 1, 6);
    cpuIdle <= 1'b0;
    rc("idle count", gtr_pkg::IDX_COUNT, 16'h0000);
    u_src.pulses(1'b0, 1, 6);
    rc("resume count", gtr_pkg::IDX_COUNT, 16'h0006);
    wr(gtr_pkg::IDX_IRQ_STATUS, 16'h0001);
    wr(gtr_pkg::IDX_PERIOD, 16'h0003);
    wr(gtr_pkg::IDX_CONTROL, 16'h8006);
    wr(gtr_pkg::IDX_COUNT, 16'h0000);
    u_src.pulses(1'b0, 3, 4);
    rc("sync count", gtr_pkg::IDX_COUNT, 16'h0003);
    u_src.pulses(1'b0, 1, 4);
    rc("sync wrap", gtr_pkg::IDX_COUNT, 16'h0000);
    rc("match", gtr_pkg::IDX_IRQ_STATUS, 16'h0001);
    cpuSleep <= 1'b1;
    u_src.pulses(1'b0, 2, 4);
    cpuSleep <= 1'b0;
    rc("sync sleep", gtr_pkg::IDX_COUNT, 16'h0000);
    wr(gtr_pkg::IDX_CONTROL, 16'h8002);
    cpuSleep <= 1'b1;
    u_src.pulses(1'b0, 2, 4);
    cpuSleep <= 1'b0;
    rc("async sleep", gtr_pkg::IDX_COUNT, 16'h0002);
    wr(gtr_pkg::IDX_CONTROL, 16'ha002);
    cpuIdle <= 1'b1;
    u_src.pulses(1'b0, 2, 4);
    cpuIdle <= 1'b0;
    rc("async idle", gtr_pkg::IDX_COUNT, 16'h0002);
    wr(gtr_pkg::IDX_IRQ_STATUS, 16'h0003);
    wr(gtr_pkg::IDX_IRQ_MASK, 16'h0003);
    wr(gtr_pkg::IDX_OSC_CTRL, 16'h0002);
    wr(gtr_pkg::IDX_CONTROL, 16'h8002);
    wr(gtr_pkg::IDX_PERIOD, 16'h0002);
    wr(gtr_pkg::IDX_COUNT, 16'h0000);
    u_src.pulses(1'b0, 2, 4);
    rc("pin ignored", gtr_pkg::IDX_COUNT, 16'h0000);
    cpuSleep <= 1'b1;
    u_src.pulses(1'b1, 2, 4);
    rc("lp count", gtr_pkg::IDX_COUNT, 16'h0002);
    u_src.pulses(1'b1, 1, 4);
    cpuSleep <= 1'b0;
    rc("lp wrap", gtr_pkg::IDX_COUNT, 16'h0000);
    rc("wake status", gtr_pkg::IDX_IRQ_STATUS, 16'h0003);
    chk("wake pulse", 32'h1, {31'h0, wakeSeen});
    chk("irq", 32'h1, {31'h0, irq});
    conclude();
  end
endmodule

// >>> rtl/gtr_pkg.sv
// package for the general timer: register map, control fields, bus types and constants
package gtr_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register indices; the byte address on the bus is four times the index
  localparam logic [ADDR_W-1:0] IDX_COUNT      = 12'h100;
  localparam logic [ADDR_W-1:0] IDX_PERIOD     = 12'h102;
  localparam logic [ADDR_W-1:0] IDX_CONTROL    = 12'h104;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 12'h106;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK   = 12'h108;
  localparam logic [ADDR_W-1:0] IDX_OSC_CTRL   = 12'h10a;
  localparam logic [ADDR_W-1:0] IDX_TO_BYTE    = 12'h004;

  // control word field positions
  localparam int unsigned CTL_TIMER_ON_BIT     = 15;
  localparam int unsigned CTL_STOP_IN_IDLE_BIT = 13;
  localparam int unsigned CTL_GATED_BIT        = 6;
  localparam int unsigned CTL_PRESCALE_HI_BIT  = 5;
  localparam int unsigned CTL_PRESCALE_LO_BIT  = 4;
  localparam int unsigned CTL_SYNC_BIT         = 2;
  localparam int unsigned CTL_SOURCE_BIT       = 1;
  localparam logic [15:0] CTL_WRITE_MASK       = 16'ha076;

  // oscillator control word: low power oscillator enable position
  localparam int unsigned OSC_LPOSC_BIT   = 1;
  localparam logic [15:0] OSC_WRITE_MASK  = 16'h0002;

  // interrupt status / mask layout
  localparam int unsigned STAT_W          = 2;
  localparam int unsigned STAT_PERIOD_BIT = 0;
  localparam int unsigned STAT_WAKE_BIT   = 1;

  // values after reset
  localparam logic [15:0]       COUNT_RST   = 16'h0000;
  localparam logic [15:0]       PERIOD_RST  = 16'hffff;
  localparam logic [15:0]       CONTROL_RST = 16'h0000;
  localparam logic [15:0]       OSC_RST     = 16'h0000;
  localparam logic [STAT_W-1:0] MASK_RST    = 2'h0;

  // prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PRESC_LIM_1   = 8'h00;
  localparam logic [7:0] PRESC_LIM_8   = 8'h07;
  localparam logic [7:0] PRESC_LIM_64  = 8'h3f;
  localparam logic [7:0] PRESC_LIM_256 = 8'hff;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_COUNT   = 3'h0,
    SEL_PERIOD  = 3'h1,
    SEL_CONTROL = 3'h2,
    SEL_STATUS  = 3'h3,
    SEL_MASK    = 3'h4,
    SEL_OSC     = 3'h5,
    SEL_NONE    = 3'h7
  } gtr_sel_e;

  typedef struct packed {
    logic       timerOn;
    logic       stopInIdle;
    logic       gatedAccumEnable;
    logic [1:0] clockPrescaleSelect;
    logic       extClockSyncSelect;
    logic       clockSourceSelect;
  } gtr_ctrl_s;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } gtr_axi_req_s;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } gtr_axi_rsp_s;

endpackage

// >>> rtl/gtr_timer.sv
// general 16-bit timer/counter with period match, gating, prescaler and low power clock, on AXI4-Lite
//
// How it works
// - timer mode: count cycles, wrap at period
// - idle with stop-in-idle halts counting
// - sync counter: synchronised pin rising edges counted
// - async counter: raw pin edges, idle halt
// - gated mode: count cycles while pin high
// - prescaler divides by 1, 8, 64, 256
// - prescaler cleared: count write, timer off, reset
// - timer off: prescaler frozen, not clearable
// - control write never changes the count
// - sleep: only async external or low power clock source keeps counting
// - period match sets flag, raises enabled irq
// - gate falling edge also sets the flag
// - low power clock edges counted with source select set and gated clear, wrap period
// - low power enable disables normal modes, wakes
// - low power counting continues through sleep only with sync select clear
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
module gtr_timer (
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  input  wire logic                 clkEn,
  input  wire gtr_pkg::gtr_axi_req_s axiReq,
  output gtr_pkg::gtr_axi_rsp_s      axiRsp,
  input  wire logic                 extClockGatePin,
  input  wire logic                 lpOscClk,
  input  wire logic                 cpuIdle,
  input  wire logic                 cpuSleep,
  output logic                      irq,
  output logic                      wakeEvent
);

  function automatic gtr_pkg::gtr_sel_e decodeSel(input logic [gtr_pkg::ADDR_W-1:0] addr);
    gtr_pkg::gtr_sel_e sel;
    sel = gtr_pkg::SEL_NONE;
    if (addr == 12'(gtr_pkg::IDX_COUNT * gtr_pkg::IDX_TO_BYTE)) begin
      sel = gtr_pkg::SEL_COUNT;
    end else if (addr == 12'(gtr_pkg::IDX_PERIOD * gtr_pkg::IDX_TO_BYTE)) begin
      sel = gtr_pkg::SEL_PERIOD;
    end else if (addr == 12'(gtr_pkg::IDX_CONTROL * gtr_pkg::IDX_TO_BYTE)) begin
      sel = gtr_pkg::SEL_CONTROL;
    end else if (addr == 12'(gtr_pkg::IDX_IRQ_STATUS * gtr_pkg::IDX_TO_BYTE)) begin
      sel = gtr_pkg::SEL_STATUS;
    end else if (addr == 12'(gtr_pkg::IDX_IRQ_MASK * gtr_pkg::IDX_TO_BYTE)) begin
      sel = gtr_pkg::SEL_MASK;
    end else if (addr == 12'(gtr_pkg::IDX_OSC_CTRL * gtr_pkg::IDX_TO_BYTE)) begin
      sel = gtr_pkg::SEL_OSC;
    end
    return sel;
  endfunction

  function automatic logic [15:0] mergeLanes(input logic [15:0] oldVal, input logic [15:0] newVal,
                                             input logic [3:0] strb);
    logic [15:0] res;
    res = oldVal;
    if (strb[0]) begin
      res[7:0] = newVal[7:0];
    end
    if (strb[1]) begin
      res[15:8] = newVal[15:8];
    end
    return res;
  endfunction

  function automatic gtr_pkg::gtr_ctrl_s unpackCtrl(input logic [15:0] w);
    gtr_pkg::gtr_ctrl_s c;
    c.timerOn             = w[gtr_pkg::CTL_TIMER_ON_BIT];
    c.stopInIdle          = w[gtr_pkg::CTL_STOP_IN_IDLE_BIT];
    c.gatedAccumEnable    = w[gtr_pkg::CTL_GATED_BIT];
    c.clockPrescaleSelect = w[gtr_pkg::CTL_PRESCALE_HI_BIT:gtr_pkg::CTL_PRESCALE_LO_BIT];
    c.extClockSyncSelect  = w[gtr_pkg::CTL_SYNC_BIT];
    c.clockSourceSelect   = w[gtr_pkg::CTL_SOURCE_BIT];
    return c;
  endfunction

  // register file
  logic [15:0]                countValue_r;
  logic [15:0]                periodValue_r;
  logic [15:0]                timerControlWord_r;
  logic [15:0]                oscillatorControl_r;
  logic [gtr_pkg::STAT_W-1:0] irqStatus_r;
  logic [gtr_pkg::STAT_W-1:0] irqMask_r;
  logic [7:0]                 prescCnt_r;

  // bus slave state
  logic                       awHeld_r;
  logic                       wHeld_r;
  logic [gtr_pkg::ADDR_W-1:0] awAddr_r;
  logic [15:0]                wData_r;
  logic [3:0]                 wStrb_r;
  logic                       awready_r;
  logic                       wready_r;
  logic                       bvalid_r;
  logic [1:0]                 bresp_r;
  logic                       arready_r;
  logic                       rvalid_r;
  logic [gtr_pkg::DATA_W-1:0] rdata_r;
  logic [1:0]                 rresp_r;

  // pin sampling, then the registered irq and wake outputs
  logic pinSync1_r;
  logic pinSync2_r;
  logic pinSyncPrev_r;
  logic pinPrev_r;
  logic lpPrev_r;
  logic irq_r;
  logic wake_r;

  gtr_pkg::gtr_ctrl_s ctl;
  gtr_pkg::gtr_sel_e  wrSel;
  logic               wrFire;
  logic               cntWr;
  logic               ctlWr;
  logic [15:0]        ctlWrVal;
  logic               tonFall;
  logic               low_power_osc_enable;
  logic               syncRise;
  logic               rawRise;
  logic               lpRise;
  logic               gateFall;
  logic               runEn;
  logic               srcPulse;
  logic               srcTick;
  logic               cntTick;
  logic               periodHit;
  logic [7:0]         prescLim;

  assign ctl     = unpackCtrl(timerControlWord_r);
  assign low_power_osc_enable = oscillatorControl_r[gtr_pkg::OSC_LPOSC_BIT];

  assign wrFire   = awHeld_r & wHeld_r & ~bvalid_r;
  assign wrSel    = decodeSel(awAddr_r);
  assign cntWr    = wrFire & (wrSel == gtr_pkg::SEL_COUNT);
  assign ctlWr    = wrFire & (wrSel == gtr_pkg::SEL_CONTROL);
  assign ctlWrVal = mergeLanes(timerControlWord_r, wData_r, wStrb_r) & gtr_pkg::CTL_WRITE_MASK;
  assign tonFall  = ctlWr & ctl.timerOn & ~ctlWrVal[gtr_pkg::CTL_TIMER_ON_BIT];

  // edge detectors; pinSync1_r feeds only pinSync2_r
  assign syncRise = pinSync2_r & ~pinSyncPrev_r;
  assign rawRise  = extClockGatePin & ~pinPrev_r;
  assign lpRise   = lpOscClk & ~lpPrev_r;
  assign gateFall = ~extClockGatePin & pinPrev_r & ctl.timerOn & ctl.gatedAccumEnable
                    & ~ctl.clockSourceSelect & ~low_power_osc_enable;

  // sleep stops the core clocks, so only an asynchronous external or low power clock source survives it
  assign runEn = ctl.timerOn & ~(cpuIdle & ctl.stopInIdle)
                 & ~(cpuSleep & ~(ctl.clockSourceSelect & ~ctl.extClockSyncSelect));

  always_comb begin
    srcPulse = 1'b0;
    if (low_power_osc_enable) begin
      // normal modes are off; only the low power clock advances the count
      srcPulse = ctl.clockSourceSelect & ~ctl.gatedAccumEnable & lpRise;
    end else if (ctl.clockSourceSelect) begin
      srcPulse = ctl.extClockSyncSelect ? syncRise : rawRise;
    end else if (ctl.gatedAccumEnable) begin
      srcPulse = extClockGatePin;
    end else begin
      srcPulse = 1'b1;
    end
  end

  assign srcTick = runEn & srcPulse;

  always_comb begin
    case (ctl.clockPrescaleSelect)
      2'h0:    prescLim = gtr_pkg::PRESC_LIM_1;
      2'h1:    prescLim = gtr_pkg::PRESC_LIM_8;
      2'h2:    prescLim = gtr_pkg::PRESC_LIM_64;
      2'h3:    prescLim = gtr_pkg::PRESC_LIM_256;
      default: prescLim = gtr_pkg::PRESC_LIM_1;
    endcase
  end

  assign cntTick   = srcTick & (prescCnt_r == prescLim);
  assign periodHit = cntTick & (countValue_r == periodValue_r);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinSync1_r    <= 1'b0;
      pinSync2_r    <= 1'b0;
      pinSyncPrev_r <= 1'b0;
      pinPrev_r     <= 1'b0;
      lpPrev_r      <= 1'b0;
    end else if (clkEn) begin
      pinSync1_r    <= extClockGatePin;
      pinSync2_r    <= pinSync1_r;
      pinSyncPrev_r <= pinSync2_r;
      pinPrev_r     <= extClockGatePin;
      lpPrev_r      <= lpOscClk;
    end
  end

  // prescaler: its clock halts with the timer, so clears only land while it runs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prescCnt_r <= 8'h00;
    end else if (clkEn) begin
      if (tonFall || (cntWr && ctl.timerOn)) begin
        prescCnt_r <= 8'h00;
      end else if (ctl.timerOn && srcTick) begin
        prescCnt_r <= (prescCnt_r == prescLim) ? 8'h00 : 8'(prescCnt_r + 8'h01);
      end
    end
  end

  // a software write to the count wins over a tick in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      countValue_r <= gtr_pkg::COUNT_RST;
    end else if (clkEn) begin
      if (cntWr) begin
        countValue_r <= mergeLanes(countValue_r, wData_r, wStrb_r);
      end else if (periodHit) begin
        countValue_r <= 16'h0000;
      end else if (cntTick) begin
        countValue_r <= 16'(countValue_r + 16'h0001);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      periodValue_r       <= gtr_pkg::PERIOD_RST;
      timerControlWord_r  <= gtr_pkg::CONTROL_RST;
      oscillatorControl_r <= gtr_pkg::OSC_RST;
      irqMask_r           <= gtr_pkg::MASK_RST;
    end else if (clkEn && wrFire) begin
      case (wrSel)
        gtr_pkg::SEL_PERIOD:  periodValue_r <= mergeLanes(periodValue_r, wData_r, wStrb_r);
        gtr_pkg::SEL_CONTROL: timerControlWord_r <= ctlWrVal;
        gtr_pkg::SEL_OSC:     oscillatorControl_r <=
                                mergeLanes(oscillatorControl_r, wData_r, wStrb_r) & gtr_pkg::OSC_WRITE_MASK;
        gtr_pkg::SEL_MASK:    irqMask_r <= wStrb_r[0] ? wData_r[gtr_pkg::STAT_W-1:0] : irqMask_r;
        default:              ;
      endcase
    end
  end

  // sticky events; a new event in the clearing cycle survives the clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStatus_r <= '0;
      irq_r       <= 1'b0;
      wake_r      <= 1'b0;
    end else if (clkEn) begin
      irqStatus_r[gtr_pkg::STAT_PERIOD_BIT] <= periodHit | gateFall
        | (irqStatus_r[gtr_pkg::STAT_PERIOD_BIT]
           & ~(wrFire && wrSel == gtr_pkg::SEL_STATUS && wStrb_r[0] && wData_r[gtr_pkg::STAT_PERIOD_BIT]));
      irqStatus_r[gtr_pkg::STAT_WAKE_BIT] <= (periodHit & low_power_osc_enable)
        | (irqStatus_r[gtr_pkg::STAT_WAKE_BIT]
           & ~(wrFire && wrSel == gtr_pkg::SEL_STATUS && wStrb_r[0] && wData_r[gtr_pkg::STAT_WAKE_BIT]));
      irq_r  <= |(irqStatus_r & irqMask_r);
      wake_r <= periodHit & low_power_osc_enable;
    end
  end

  // write channels are taken independently; the response follows both
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_r  <= 1'b0;
      wHeld_r   <= 1'b0;
      awAddr_r  <= '0;
      wData_r   <= 16'h0000;
      wStrb_r   <= 4'h0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= gtr_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (axiReq.awvalid && awready_r) begin
        awHeld_r  <= 1'b1;
        awAddr_r  <= axiReq.awaddr;
        awready_r <= 1'b0;
      end
      if (axiReq.wvalid && wready_r) begin
        wHeld_r  <= 1'b1;
        wData_r  <= axiReq.wdata[15:0];
        wStrb_r  <= axiReq.wstrb;
        wready_r <= 1'b0;
      end
      if (wrFire) begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= (wrSel == gtr_pkg::SEL_NONE) ? gtr_pkg::RESP_SLVERR : gtr_pkg::RESP_OKAY;
      end
      if (bvalid_r && axiReq.bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= gtr_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (axiReq.arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rresp_r   <= gtr_pkg::RESP_OKAY;
        case (decodeSel(axiReq.araddr))
          gtr_pkg::SEL_COUNT:   rdata_r <= {16'h0000, countValue_r};
          gtr_pkg::SEL_PERIOD:  rdata_r <= {16'h0000, periodValue_r};
          gtr_pkg::SEL_CONTROL: rdata_r <= {16'h0000, timerControlWord_r};
          gtr_pkg::SEL_STATUS:  rdata_r <= {30'h0, irqStatus_r};
          gtr_pkg::SEL_MASK:    rdata_r <= {30'h0, irqMask_r};
          gtr_pkg::SEL_OSC:     rdata_r <= {16'h0000, oscillatorControl_r};
          default: begin
            rdata_r <= '0;
            rresp_r <= gtr_pkg::RESP_SLVERR;
          end
        endcase
      end
      if (rvalid_r && axiReq.rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign axiRsp.awready = awready_r;
  assign axiRsp.wready  = wready_r;
  assign axiRsp.bvalid  = bvalid_r;
  assign axiRsp.bresp   = bresp_r;
  assign axiRsp.arready = arready_r;
  assign axiRsp.rvalid  = rvalid_r;
  assign axiRsp.rdata   = rdata_r;
  assign axiRsp.rresp   = rresp_r;
  assign irq            = irq_r;
  assign wakeEvent      = wake_r;

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  AST_WRAP_AT_PERIOD: assert property (clkEn && periodHit && !cntWr |=> countValue_r == 16'h0000)
    else $error("count did not wrap to zero at period match");
  AST_INCREMENT: assert property (clkEn && cntTick && !periodHit && !cntWr
                                  |=> countValue_r == 16'($past(countValue_r) + 16'h0001))
    else $error("count did not advance by one on a tick");
  AST_IDLE_HALT: assert property (clkEn && cpuIdle && ctl.stopInIdle && !cntWr
                                  |=> countValue_r == $past(countValue_r))
    else $error("count moved while idle with stop-in-idle set");
  AST_SYNC_EDGE_ONLY: assert property (clkEn && !low_power_osc_enable && ctl.clockSourceSelect && ctl.extClockSyncSelect
                                       && !syncRise |-> !srcTick)
    else $error("sync counter ticked without a synchronised edge");
  AST_GATE_LOW_HOLD: assert property (clkEn && !low_power_osc_enable && ctl.gatedAccumEnable && !ctl.clockSourceSelect
                                      && !extClockGatePin && !cntWr |=> countValue_r == $past(countValue_r))
    else $error("gated count changed with gate low");
  AST_PRESC_CLEAR: assert property (clkEn && cntWr && ctl.timerOn |=> prescCnt_r == 8'h00)
    else $error("prescaler not cleared by count write");
  AST_PRESC_FROZEN: assert property (clkEn && !ctl.timerOn |=> prescCnt_r == $past(prescCnt_r))
    else $error("prescaler changed while timer off");
  AST_CTL_KEEPS_COUNT: assert property (clkEn && ctlWr && !cntTick |=> countValue_r == $past(countValue_r))
    else $error("control write changed the count");
  AST_SLEEP_SOURCE: assert property (clkEn && cpuSleep && !(ctl.clockSourceSelect && !ctl.extClockSyncSelect)
                                     |-> !srcTick)
    else $error("count ticked in sleep without async external source");
  AST_FLAG_ON_MATCH: assert property (clkEn && periodHit ##1 clkEn && irqMask_r[0] |=> irq)
    else $error("match did not raise enabled interrupt two cycles later");
  AST_GATE_FALL_FLAG: assert property (clkEn && gateFall |=> irqStatus_r[gtr_pkg::STAT_PERIOD_BIT])
    else $error("gate falling edge did not set the flag");
  AST_LPOSC_ONLY: assert property (clkEn && low_power_osc_enable && !lpRise |-> !srcTick)
    else $error("normal mode ticked while low power clock selected");

  COV_WRAP:      cover property (clkEn && periodHit);
  COV_GATE_FALL: cover property (clkEn && gateFall);
  COV_WAKE:      cover property (wakeEvent);
  COV_BUS_WRITE: cover property (clkEn && cntWr);

endmodule
